// *** rtl/asq_cfg.svh ***
`ifndef ASQ_CFG_SVH
`define ASQ_CFG_SVH

// ****************************************************************
// Register indices on the local register port.
// ****************************************************************
`define ASQ_IDX_RES_HIGH 3'h0
`define ASQ_IDX_RES_LOW 3'h1
`define ASQ_IDX_CTRL 3'h2
`define ASQ_IDX_SRC_CLK 3'h3
`define ASQ_IDX_MODE 3'h4

// ****************************************************************
// Field positions.
// ****************************************************************
`define ASQ_CTRL_START 7
`define ASQ_CTRL_BUSY 6
`define ASQ_CTRL_EN 5
`define ASQ_CTRL_JUST 4
`define ASQ_CTRL_CH_HI 3
`define ASQ_CTRL_CH_LO 0
`define ASQ_SRC_SEL_HI 7
`define ASQ_SRC_SEL_LO 5
`define ASQ_SRC_REF_HI 4
`define ASQ_SRC_REF_LO 3
`define ASQ_SRC_DIV_HI 2
`define ASQ_SRC_DIV_LO 0
`define ASQ_MODE_RATE_HI 7
`define ASQ_MODE_RATE_LO 6
`define ASQ_MODE_RES 5
`define ASQ_MODE_D1 1
`define ASQ_MODE_THERMAL_SENSOR_ENABLE 0

// ****************************************************************
// Reset values and special codes.
// ****************************************************************
`define ASQ_CTRL_RST 8'h00
`define ASQ_SRC_CLK_RST 8'h00
`define ASQ_MODE_RST 8'h02
`define ASQ_MODE_WMASK 8'hE3
`define ASQ_SRC_FORBIDDEN 3'h7
`define ASQ_CH_PINS 8

`endif

// *** rtl/asq_pkg.sv ***
package asq_pkg;

  typedef enum logic [2:0] {
    ASQ_SRC_EXT,
    ASQ_SRC_BG,
    ASQ_SRC_TS,
    ASQ_SRC_GND,
    ASQ_SRC_BAD
  } asq_src_t;

  typedef enum logic [1:0] {
    ASQ_ST_IDLE,
    ASQ_ST_ARM,
    ASQ_ST_WAIT
  } asq_state_t;

  // Maps the input source code onto the signal that reaches the converter.
  function automatic asq_src_t asq_src_decode(input logic [2:0] code);
    asq_src_t s;
    s = ASQ_SRC_BAD;
    case (code)
      3'h0, 3'h5, 3'h6: s = ASQ_SRC_EXT;
      3'h1: s = ASQ_SRC_BG;
      3'h2: s = ASQ_SRC_TS;
      3'h3, 3'h4: s = ASQ_SRC_GND;
      default: s = ASQ_SRC_BAD;
    endcase
    return s;
  endfunction : asq_src_decode

endpackage : asq_pkg

// *** rtl/asq_pack.sv ***
`timescale 1ns/1ps
`default_nettype none

module asq_pack (
  input wire logic [11:0] data,
  input wire logic res_10b,
  input wire logic justify,
  output logic [7:0] hi,
  output logic [7:0] lo
);

  always_comb
  begin
    hi = 8'h00;
    lo = 8'h00;
    case ({res_10b, justify})
      2'b00:
      begin
        hi = data[11:4];
        lo = {data[3:0], 4'h0};
      end
      2'b01:
      begin
        hi = {4'h0, data[11:8]};
        lo = data[7:0];
      end
      2'b10:
      begin
        hi = data[9:2];
        lo = {data[1:0], 6'h00};
      end
      default:
      begin
        hi = {6'h00, data[9:8]};
        lo = data[7:0];
      end
    endcase
  end

endmodule : asq_pack

`default_nettype wire

// *** rtl/asq_conv.sv ***
`timescale 1ns/1ps
`default_nettype none

module asq_conv (
  input wire logic clk,
  input wire logic rst,
  input wire logic launch,
  input wire logic enable,
  input wire logic conv_done,
  output logic finish,
  output logic busy,
  output logic start_pulse
);

  asq_pkg::asq_state_t state_r;
  asq_pkg::asq_state_t state_nxt;
  logic busy_r;
  logic busy_nxt;
  logic start_r;
  logic start_nxt;

  assign busy = busy_r;
  assign start_pulse = start_r;
  assign finish = (state_r == asq_pkg::ASQ_ST_WAIT) && enable && conv_done;

  always_comb
  begin
    state_nxt = state_r;
    busy_nxt = busy_r;
    start_nxt = 1'b0;
    case (state_r)
      asq_pkg::ASQ_ST_IDLE:
      begin
        // A launch while busy can never be seen here, so it is dropped.
        if (launch && enable)
        begin
          state_nxt = asq_pkg::ASQ_ST_ARM;
          busy_nxt = 1'b1;
          start_nxt = 1'b1;
        end
      end
      asq_pkg::ASQ_ST_ARM:
      begin
        state_nxt = asq_pkg::ASQ_ST_WAIT;
      end
      asq_pkg::ASQ_ST_WAIT:
      begin
        // Switching the converter off abandons the conversion.
        if (!enable)
        begin
          state_nxt = asq_pkg::ASQ_ST_IDLE;
          busy_nxt = 1'b0;
        end
        else if (conv_done)
        begin
          state_nxt = asq_pkg::ASQ_ST_IDLE;
          busy_nxt = 1'b0;
        end
      end
      default:
      begin
        state_nxt = asq_pkg::ASQ_ST_IDLE;
        busy_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r <= asq_pkg::ASQ_ST_IDLE;
      busy_r <= 1'b0;
      start_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      busy_r <= busy_nxt;
      start_r <= start_nxt;
    end
  end

endmodule : asq_conv

`default_nettype wire

// *** rtl/asq_top.sv ***
`include "asq_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module asq_top (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [2:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic CONV_DONE,
  input wire logic [11:0] CONV_DATA,
  input wire logic [7:0] PIN_ANALOG_SEL,
  input wire logic [7:0] GPIO_OE_IN,
  input wire logic [7:0] PULLUP_IN,
  output logic CONV_POWER_EN,
  output logic CONV_START,
  output logic CONV_RES_10B,
  output logic [1:0] CONV_RATE_MODE,
  output logic [2:0] CONV_CLK_DIV,
  output logic [1:0] CONV_REF_SEL,
  output logic THERMAL_EN,
  output logic [7:0] CH_CONNECT,
  output logic INT_SRC_BG,
  output logic INT_SRC_TS,
  output logic INT_SRC_GND,
  output logic [7:0] GPIO_OE,
  output logic [7:0] PULLUP_EN,
  output logic CONV_IRQ
);

  // ****************************************************************
  // Register state.
  // ****************************************************************
  logic start_bit_r;
  logic start_bit_nxt;
  logic enable_r;
  logic enable_nxt;
  logic justify_r;
  logic justify_nxt;
  logic [3:0] channel_r;
  logic [3:0] channel_nxt;
  logic [7:0] src_clk_r;
  logic [7:0] src_clk_nxt;
  logic [7:0] mode_r;
  logic [7:0] mode_nxt;
  logic [7:0] res_high_r;
  logic [7:0] res_high_nxt;
  logic [7:0] res_low_r;
  logic [7:0] res_low_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic launch;

  // ****************************************************************
  // Routing and pin state.
  // ****************************************************************
  logic [7:0] ch_connect_r;
  logic [7:0] ch_connect_nxt;
  logic int_bg_r;
  logic int_bg_nxt;
  logic int_ts_r;
  logic int_ts_nxt;
  logic int_gnd_r;
  logic int_gnd_nxt;
  logic [7:0] gpio_oe_r;
  logic [7:0] gpio_oe_nxt;
  logic [7:0] pullup_r;
  logic [7:0] pullup_nxt;
  logic irq_r;
  logic irq_nxt;
  logic power_r;
  logic power_nxt;

  logic finish;
  logic busy;
  logic start_pulse;
  logic [7:0] pack_hi;
  logic [7:0] pack_lo;
  logic wr_ctrl;
  logic wr_src;
  logic wr_mode;
  asq_pkg::asq_src_t src_kind;

  assign wr_ctrl = REG_WR && (REG_ADDR == `ASQ_IDX_CTRL);
  assign wr_src = REG_WR && (REG_ADDR == `ASQ_IDX_SRC_CLK);
  assign wr_mode = REG_WR && (REG_ADDR == `ASQ_IDX_MODE);
  assign src_kind = asq_pkg::asq_src_decode(src_clk_r[`ASQ_SRC_SEL_HI:`ASQ_SRC_SEL_LO]);

  // ****************************************************************
  // Conversion sequencer and result formatting.
  // ****************************************************************
  asq_conv u_conv (
    .clk(CLK),
    .rst(RST),
    .launch(launch),
    .enable(enable_r),
    .conv_done(CONV_DONE),
    .finish(finish),
    .busy(busy),
    .start_pulse(start_pulse)
  );

  // Formatting follows the resolution and justification in force at completion.
  asq_pack u_pack (
    .data(CONV_DATA),
    .res_10b(mode_r[`ASQ_MODE_RES]),
    .justify(justify_r),
    .hi(pack_hi),
    .lo(pack_lo)
  );

  // ****************************************************************
  // Control register writes and start detection.
  // ****************************************************************
  always_comb
  begin
    start_bit_nxt = start_bit_r;
    enable_nxt = enable_r;
    justify_nxt = justify_r;
    channel_nxt = channel_r;
    launch = 1'b0;
    if (wr_ctrl)
    begin
      // The busy position of the write data is simply not looked at.
      start_bit_nxt = REG_WDATA[`ASQ_CTRL_START];
      enable_nxt = REG_WDATA[`ASQ_CTRL_EN];
      justify_nxt = REG_WDATA[`ASQ_CTRL_JUST];
      channel_nxt = REG_WDATA[`ASQ_CTRL_CH_HI:`ASQ_CTRL_CH_LO];
      // Only the falling half of a high-then-low pair launches.
      launch = start_bit_r && !REG_WDATA[`ASQ_CTRL_START];
    end
  end

  always_comb
  begin
    src_clk_nxt = src_clk_r;
    mode_nxt = mode_r;
    if (wr_src)
    begin
      src_clk_nxt[`ASQ_SRC_REF_HI:`ASQ_SRC_DIV_LO] = REG_WDATA[`ASQ_SRC_REF_HI:`ASQ_SRC_DIV_LO];
      // The forbidden source code is refused; the old code stays.
      if (REG_WDATA[`ASQ_SRC_SEL_HI:`ASQ_SRC_SEL_LO] != `ASQ_SRC_FORBIDDEN)
      begin
        src_clk_nxt[`ASQ_SRC_SEL_HI:`ASQ_SRC_SEL_LO] =
          REG_WDATA[`ASQ_SRC_SEL_HI:`ASQ_SRC_SEL_LO];
      end
    end
    if (wr_mode)
    begin
      mode_nxt = REG_WDATA & `ASQ_MODE_WMASK;
    end
  end

  // ****************************************************************
  // Result bytes.
  // ****************************************************************
  always_comb
  begin
    res_high_nxt = res_high_r;
    res_low_nxt = res_low_r;
    // Finish is only possible while enabled, so a disabled block holds.
    if (finish)
    begin
      res_high_nxt = pack_hi;
      res_low_nxt = pack_lo;
    end
  end

  // ****************************************************************
  // Read port.
  // ****************************************************************
  always_comb
  begin
    rdata_nxt = 8'h00;
    if (REG_RD)
    begin
      case (REG_ADDR)
        `ASQ_IDX_RES_HIGH: rdata_nxt = res_high_r;
        `ASQ_IDX_RES_LOW: rdata_nxt = res_low_r;
        `ASQ_IDX_CTRL: rdata_nxt = {start_bit_r, busy, enable_r, justify_r, channel_r};
        `ASQ_IDX_SRC_CLK: rdata_nxt = src_clk_r;
        `ASQ_IDX_MODE: rdata_nxt = mode_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Source routing.
  // ****************************************************************
  always_comb
  begin
    ch_connect_nxt = 8'h00;
    int_bg_nxt = 1'b0;
    int_ts_nxt = 1'b0;
    int_gnd_nxt = 1'b0;
    // Nothing is routed while the converter is off.
    if (enable_r)
    begin
      case (src_kind)
        asq_pkg::ASQ_SRC_EXT:
        begin
          // Codes at or above the pin count leave the input floating.
          if (channel_r < 4'(`ASQ_CH_PINS))
          begin
            ch_connect_nxt = 8'h01 << channel_r[2:0];
          end
        end
        asq_pkg::ASQ_SRC_BG: int_bg_nxt = 1'b1;
        asq_pkg::ASQ_SRC_TS: int_ts_nxt = 1'b1;
        asq_pkg::ASQ_SRC_GND: int_gnd_nxt = 1'b1;
        default:
        begin
          ch_connect_nxt = 8'h00;
        end
      endcase
    end
  end
  // Pins stay cut off whenever an internal source is chosen, so a slip
  // in software cannot short a pin onto an internal node.

  // ****************************************************************
  // Pin function gating, power and completion request.
  // ****************************************************************
  always_comb
  begin
    gpio_oe_nxt = GPIO_OE_IN & ~PIN_ANALOG_SEL;
    pullup_nxt = PULLUP_IN & ~PIN_ANALOG_SEL;
    power_nxt = enable_r;
    irq_nxt = finish;
  end

  // ****************************************************************
  // Registers.
  // ****************************************************************
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      start_bit_r <= 1'(`ASQ_CTRL_RST >> `ASQ_CTRL_START);
      enable_r <= 1'b0;
      justify_r <= 1'b0;
      channel_r <= 4'h0;
      src_clk_r <= `ASQ_SRC_CLK_RST;
      mode_r <= `ASQ_MODE_RST;
      res_high_r <= 8'h00;
      res_low_r <= 8'h00;
      rdata_r <= 8'h00;
      ch_connect_r <= 8'h00;
      int_bg_r <= 1'b0;
      int_ts_r <= 1'b0;
      int_gnd_r <= 1'b0;
      gpio_oe_r <= 8'h00;
      pullup_r <= 8'h00;
      power_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      start_bit_r <= start_bit_nxt;
      enable_r <= enable_nxt;
      justify_r <= justify_nxt;
      channel_r <= channel_nxt;
      src_clk_r <= src_clk_nxt;
      mode_r <= mode_nxt;
      res_high_r <= res_high_nxt;
      res_low_r <= res_low_nxt;
      rdata_r <= rdata_nxt;
      ch_connect_r <= ch_connect_nxt;
      int_bg_r <= int_bg_nxt;
      int_ts_r <= int_ts_nxt;
      int_gnd_r <= int_gnd_nxt;
      gpio_oe_r <= gpio_oe_nxt;
      pullup_r <= pullup_nxt;
      power_r <= power_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign REG_RDATA = rdata_r;
  assign CONV_POWER_EN = power_r;
  assign CONV_START = start_pulse;
  assign CONV_RES_10B = mode_r[`ASQ_MODE_RES];
  assign CONV_RATE_MODE = mode_r[`ASQ_MODE_RATE_HI:`ASQ_MODE_RATE_LO];
  assign CONV_CLK_DIV = src_clk_r[`ASQ_SRC_DIV_HI:`ASQ_SRC_DIV_LO];
  assign CONV_REF_SEL = src_clk_r[`ASQ_SRC_REF_HI:`ASQ_SRC_REF_LO];
  // The thermal source is only valid at 12-bit and the fastest rate;
  // that is left to software and not enforced here.
  assign THERMAL_EN = mode_r[`ASQ_MODE_THERMAL_SENSOR_ENABLE];
  assign CH_CONNECT = ch_connect_r;
  assign INT_SRC_BG = int_bg_r;
  assign INT_SRC_TS = int_ts_r;
  assign INT_SRC_GND = int_gnd_r;
  assign GPIO_OE = gpio_oe_r;
  assign PULLUP_EN = pullup_r;
  assign CONV_IRQ = irq_r;

endmodule : asq_top

`default_nettype wire

// *** verification/asq_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// ********
// Port-level checks of the sequencer, source routing and pin gating.
// ********
module asq_checker (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [2:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic CONV_DONE,
  input wire logic [7:0] PIN_ANALOG_SEL,
  input wire logic [7:0] GPIO_OE_IN,
  input wire logic [7:0] PULLUP_IN,
  input wire logic CONV_POWER_EN,
  input wire logic CONV_START,
  input wire logic [7:0] CH_CONNECT,
  input wire logic INT_SRC_BG,
  input wire logic INT_SRC_TS,
  input wire logic INT_SRC_GND,
  input wire logic [7:0] GPIO_OE,
  input wire logic [7:0] PULLUP_EN,
  input wire logic CONV_IRQ
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  // Tracks a launched conversion until the macro finishes or power drops.
  logic run_r;
  logic run_nxt;
  always_comb
  begin
    run_nxt = run_r;
    if (CONV_START)
      run_nxt = 1'b1;
    if (CONV_DONE || !CONV_POWER_EN || RST)
      run_nxt = 1'b0;
  end
  always_ff @(posedge CLK)
    run_r <= run_nxt;
  sequence s_quiet;
    !CONV_START ##1 !CONV_START;
  endsequence
  sequence s_go_wr;
    REG_WR && REG_ADDR == 3'h2 && !REG_WDATA[7];
  endsequence
  property p_start_cause;
    CONV_START |-> $past(REG_WR) && $past(REG_ADDR) == 3'h2 && !$past(REG_WDATA[7]);
  endproperty
  property p_start_quiet;
    CONV_START |=> s_quiet;
  endproperty
  property p_start_pwr;
    s_go_wr ##1 CONV_START |-> CONV_POWER_EN;
  endproperty
  property p_no_restart;
    CONV_START |-> !run_r;
  endproperty
  property p_irq_cause;
    CONV_IRQ |-> $past(CONV_DONE) && !CONV_START;
  endproperty
  property p_route;
    $onehot0({CH_CONNECT, INT_SRC_BG, INT_SRC_TS, INT_SRC_GND});
  endproperty
  property p_gpio;
    !$past(RST) |-> GPIO_OE == ($past(GPIO_OE_IN) & ~$past(PIN_ANALOG_SEL));
  endproperty
  property p_pull;
    !$past(RST) |-> PULLUP_EN == ($past(PULLUP_IN) & ~$past(PIN_ANALOG_SEL));
  endproperty
  a_start_cause: assert property (p_start_cause)
    else $error("start without launch write");
  a_start_quiet: assert property (p_start_quiet)
    else $error("start pulse repeated");
  a_start_pwr: assert property (p_start_pwr)
    else $error("start while unpowered");
  a_no_restart: assert property (p_no_restart)
    else $error("start while busy");
  a_irq_cause: assert property (p_irq_cause)
    else $error("irq without completion");
  a_route: assert property (p_route)
    else $error("more than one source routed");
  a_gpio: assert property (p_gpio)
    else $error("gpio enable not masked");
  a_pull: assert property (p_pull)
    else $error("pull-up not masked");
  property p_irq_once;
    CONV_IRQ |=> !CONV_IRQ;
  endproperty
  a_irq_once: assert property (p_irq_once)
    else $error("irq longer than one cycle");
endmodule : asq_checker
`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
// ********
// Register-level bench.
// ********
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic done = 1'b0;
  logic [11:0] data = 12'h000;
  logic [7:0] asel = 8'h0F;
  logic [7:0] oe_in = 8'hFF;
  logic [7:0] pu_in = 8'h3C;
  logic [7:0] rdata, ch, oe, pu;
  logic pwr, start, r10, bg, ts, gnd, irq, thermal_sensor_enable;
  logic [1:0] rate, refs;
  logic [2:0] div;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  asq_top u_dut (.CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .CONV_DONE(done), .CONV_DATA(data),
    .PIN_ANALOG_SEL(asel), .GPIO_OE_IN(oe_in), .PULLUP_IN(pu_in), .CONV_POWER_EN(pwr),
    .CONV_START(start), .CONV_RES_10B(r10), .CONV_RATE_MODE(rate), .CONV_CLK_DIV(div),
    .CONV_REF_SEL(refs), .THERMAL_EN(thermal_sensor_enable), .CH_CONNECT(ch), .INT_SRC_BG(bg),
    .INT_SRC_TS(ts),
    .INT_SRC_GND(gnd), .GPIO_OE(oe), .PULLUP_EN(pu), .CONV_IRQ(irq));
  always #2 clk = ~clk;
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask : rd_reg
  task automatic end_conv(input logic [11:0] d);
    @(posedge clk);
    data <= d;
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
  endtask : end_conv
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  // The whole run needs about 240 cycles; the ceiling leaves ample margin.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  initial
  begin
    logic [11:0] d;
    logic [7:0] eh, el;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_reg(3'h2, 8'h00);
    rd_reg(3'h3, 8'h00);
    rd_reg(3'h4, 8'h02);
    wr_reg(3'h2, 8'h40);
    rd_reg(3'h2, 8'h00);
    wr_reg(3'h2, 8'h80);
    wr_reg(3'h2, 8'h00);
    @(negedge clk);
    chk(start, 1'b0);
    rd_reg(3'h2, 8'h00);
    wr_reg(3'h5, 8'hFF);
    rd_reg(3'h5, 8'h00);
    wr_reg(3'h4, 8'hFF);
    rd_reg(3'h4, 8'hE3);
    chk({rate, r10, thermal_sensor_enable}, 4'hF);
    chk(oe, 8'hF0);
    chk(pu, 8'h30);
    $display("test registers done");
    for (int i = 0; i < 4; i++)
    begin
      d = {i[1:0], 2'h3, i[1:0], 6'h29};
      wr_reg(3'h4, {2'h0, i[1], 5'h02});
      wr_reg(3'h2, {3'h5, i[0], 4'h3});
      rd_reg(3'h2, {3'h5, i[0], 4'h3});
      wr_reg(3'h2, {3'h1, i[0], 4'h3});
      @(negedge clk);
      chk(start, 1'b1);
      rd_reg(3'h2, {3'h3, i[0], 4'h3});
      wr_reg(3'h2, {3'h5, i[0], 4'h3});
      wr_reg(3'h2, {3'h1, i[0], 4'h3});
      @(negedge clk);
      chk(start, 1'b0);
      rd_reg(3'h2, {3'h3, i[0], 4'h3});
      end_conv(d);
      @(negedge clk);
      chk(irq, 1'b1);
      rd_reg(3'h2, {3'h1, i[0], 4'h3});
      eh = i[1] ? (i[0] ? {6'h00, d[9:8]} : d[9:2]) : (i[0] ? {4'h0, d[11:8]} : d[11:4]);
      el = i[0] ? d[7:0] : (i[1] ? {d[1:0], 6'h00} : {d[3:0], 4'h0});
      rd_reg(3'h0, eh);
      rd_reg(3'h1, el);
      chk(r10, i[1]);
    end
    $display("test conversion done");
    wr_reg(3'h2, 8'hB3);
    wr_reg(3'h2, 8'h33);
    wr_reg(3'h2, 8'h00);
    // Completion arrives while the sequencer still waits but enable is already gone.
    data <= 12'h000;
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    @(negedge clk);
    chk(irq, 1'b0);
    rd_reg(3'h2, 8'h00);
    end_conv(12'h000);
    rd_reg(3'h0, eh);
    rd_reg(3'h1, el);
    chk(pwr, 1'b0);
    $display("test disable done");
    wr_reg(3'h4, 8'h03);
    @(negedge clk);
    chk({rate, r10, thermal_sensor_enable}, 4'h1);
    for (int c = 0; c < 16; c++)
    begin
      wr_reg(3'h2, 8'h20 | 8'(c));
      repeat (2) @(negedge clk);
      chk(ch, c < 8 ? 8'h01 << c : 8'h00);
    end
    wr_reg(3'h2, 8'h23);
    for (int s = 0; s < 7; s++)
    begin
      // Pins are parked on a floating code while the source changes.
      wr_reg(3'h2, 8'h28);
      wr_reg(3'h3, {s[2:0], 5'h00});
      if (s == 0 || s > 4)
        wr_reg(3'h2, 8'h23);
      repeat (2) @(negedge clk);
      chk({ch, bg, ts, gnd}, {(s == 0 || s > 4) ? 8'h08 : 8'h00, s == 1, s == 2, s == 3 || s == 4});
    end
    wr_reg(3'h3, 8'hE7);
    rd_reg(3'h3, 8'hC7);
    chk({refs, div}, 5'h07);
    wr_reg(3'h3, 8'hF8);
    rd_reg(3'h3, 8'hD8);
    chk({refs, div}, 5'h18);
    $display("test routing done");
    give_verdict();
  end
endmodule : testbench
bind asq_top asq_checker u_chk (.CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .CONV_DONE(CONV_DONE),
  .PIN_ANALOG_SEL(PIN_ANALOG_SEL), .GPIO_OE_IN(GPIO_OE_IN), .PULLUP_IN(PULLUP_IN),
  .CONV_POWER_EN(CONV_POWER_EN), .CONV_START(CONV_START), .CH_CONNECT(CH_CONNECT),
  .INT_SRC_BG(INT_SRC_BG), .INT_SRC_TS(INT_SRC_TS), .INT_SRC_GND(INT_SRC_GND),
  .GPIO_OE(GPIO_OE), .PULLUP_EN(PULLUP_EN), .CONV_IRQ(CONV_IRQ));
`default_nettype wire
